// ===== rtl/sfr_pkg.sv
// Feature register bank: constants, field positions, commands, states.
// Assumes a serial host link of one opcode byte, one address byte, data.
package sfr_pkg;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] CMD_GET = 8'h0f;
	localparam logic [7:0] CMD_SET = 8'h1f;
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_RST_A = 8'hff;
	localparam logic [7:0] CMD_RST_B = 8'hfe;
	localparam logic [7:0] CMD_PROT = 8'h2a;
	// ----------------------------------------
	// Feature addresses
	// ----------------------------------------
	localparam logic [7:0] ADR_THR = 8'h10;
	localparam logic [7:0] ADR_SUM = 8'h20;
	localparam logic [7:0] ADR_MAX = 8'h30;
	localparam logic [7:0] ADR_REP0 = 8'h40;
	localparam logic [7:0] ADR_REP1 = 8'h50;
	localparam logic [7:0] ADR_REP2 = 8'h60;
	localparam logic [7:0] ADR_REP3 = 8'h70;
	localparam logic [7:0] ADR_LOCK = 8'ha0;
	localparam logic [7:0] ADR_CONF = 8'hb0;
	localparam logic [7:0] ADR_STAT = 8'hc0;
	// ----------------------------------------
	// Field positions and reserved masks
	// ----------------------------------------
	localparam int LK_WD = 7;
	localparam int LK_RNG_HI = 5;
	localparam int LK_RNG_LO = 3;
	localparam int CF_PROT = 7;
	localparam int CF_IDR = 6;
	localparam int CF_ECC = 4;
	localparam int CF_FAST = 1;
	localparam int TH_HI = 7;
	localparam int TH_LO = 4;
	localparam int ST_OIP = 0;
	localparam logic [7:0] RSV_LOCK = 8'h47;
	localparam logic [7:0] RSV_CONF = 8'h29;
	localparam logic [7:0] RSV_STAT = 8'hc0;
	// ----------------------------------------
	// Defaults and encodings
	// ----------------------------------------
	localparam logic [2:0] DEF_RANGE = 3'h7;
	localparam logic DEF_ECC = 1'b1;
	localparam logic DEF_FAST = 1'b1;
	localparam logic [3:0] DEF_THR = 4'h0;
	localparam logic BBI_VAL = 1'b1;
	localparam logic [1:0] CS_NONE = 2'h0;
	localparam logic [1:0] CS_LOW = 2'h1;
	localparam logic [1:0] CS_UNCORR = 2'h2;
	localparam logic [1:0] CS_HIGH = 2'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;

	typedef enum logic [4:0] {
		ST_CMD = 5'h01,
		ST_ADR = 5'h02,
		ST_WR = 5'h04,
		ST_RD = 5'h08,
		ST_SKIP = 5'h10
	} sfr_state_e;

	typedef struct packed {
		logic lock_reg_write_disable;
		logic [2:0] lock_range;
		logic protect_enable;
		logic id_read_enable;
		logic ecc_enable;
		logic fast_read_enable;
		logic [3:0] flip_threshold_field;
		logic write_enable_latch;
	} sfr_cfg_s;

	typedef struct packed {
		logic op_in_progress;
		logic program_fail_flag;
		logic erase_fail_flag;
		logic ecc_done;
		logic ecc_uncorr;
		logic [3:0] ecc_flips;
		logic [7:0] flip_count_summary_field;
		logic [3:0] max_flip_field;
		logic [2:0] max_flip_sector;
		logic [31:0] flip_report_field;
	} sfr_core_s;
endpackage : sfr_pkg

// ===== rtl/sfr_top.sv
// Feature register bank behind the serial host link.
// Assumes mode 0 link sampled by clk (clk well above 4x sclk) and
// core status arriving synchronous to clk.
`timescale 1ns/1ns
module sfr_top import sfr_pkg::*; (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial link pins
	input wire logic cs_b,
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic wp_b,
	// Core side
	input wire sfr_core_s core,
	output sfr_cfg_s cfg,
	output logic soft_reset,
	output logic protect_go
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] cs_sync_ff;
	logic [1:0] sck_sync_ff;
	logic [1:0] mosi_sync_ff;
	logic [1:0] wp_sync_ff;
	logic sck_d_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_sync_ff <= 2'h3;
			sck_sync_ff <= 2'h0;
			mosi_sync_ff <= 2'h0;
			wp_sync_ff <= 2'h3;
			sck_d_ff <= 1'b0;
		end else begin
			cs_sync_ff <= {cs_sync_ff[0], cs_b};
			sck_sync_ff <= {sck_sync_ff[0], sclk};
			mosi_sync_ff <= {mosi_sync_ff[0], mosi};
			wp_sync_ff <= {wp_sync_ff[0], wp_b};
			sck_d_ff <= sck_sync_ff[1];
		end
	end

	wire cs_act = ~cs_sync_ff[1];
	wire wp_low = ~wp_sync_ff[1];
	wire sck_rise = cs_act & sck_sync_ff[1] & ~sck_d_ff;
	wire sck_fall = cs_act & ~sck_sync_ff[1] & sck_d_ff;

	// ----------------------------------------
	// Byte framing
	// ----------------------------------------
	sfr_state_e state_ff;
	sfr_state_e nxt_state;
	logic [2:0] bit_cnt_ff;
	logic [6:0] rx_ff;
	logic is_get_ff;
	logic [7:0] addr_ff;
	logic [7:0] tx_ff;

	wire [7:0] rx_byte = {rx_ff, mosi_sync_ff[1]};
	wire byte_done = sck_rise & (bit_cnt_ff == BIT_LAST);
	wire in_cmd = state_ff == ST_CMD;
	wire in_adr = state_ff == ST_ADR;
	wire in_wr = state_ff == ST_WR;
	wire in_rd = state_ff == ST_RD;
	wire cmd_done = byte_done & in_cmd;
	wire wr_done = byte_done & in_wr;
	wire is_feat = (rx_byte == CMD_GET) | (rx_byte == CMD_SET);
	wire is_wren = rx_byte == CMD_WREN;
	wire is_wrdi = rx_byte == CMD_WRDI;
	wire is_rst = (rx_byte == CMD_RST_A) | (rx_byte == CMD_RST_B);
	wire is_prot = rx_byte == CMD_PROT;

	always_comb begin
		nxt_state = state_ff;
		if (!cs_act) begin
			nxt_state = ST_CMD;
		end else if (byte_done) begin
			case (state_ff)
				ST_CMD: nxt_state = is_feat ? ST_ADR : ST_SKIP;
				ST_ADR: nxt_state = is_get_ff ? ST_RD : ST_WR;
				ST_WR: nxt_state = ST_SKIP;
				default: nxt_state = state_ff;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= ST_CMD;
			bit_cnt_ff <= 3'h0;
			rx_ff <= 7'h00;
		end else begin
			state_ff <= nxt_state;
			bit_cnt_ff <= !cs_act ? 3'h0 : bit_cnt_ff + 3'(sck_rise);
			if (sck_rise)
				rx_ff <= rx_byte[6:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			is_get_ff <= 1'b0;
			addr_ff <= 8'h00;
		end else begin
			if (cmd_done)
				is_get_ff <= rx_byte == CMD_GET;
			if (byte_done & in_adr)
				addr_ff <= rx_byte;
		end
	end

	// ----------------------------------------
	// Feature settings
	// ----------------------------------------
	sfr_cfg_s cfg_ff;
	sfr_cfg_s nxt_cfg;
	logic [1:0] corr_ff;
	logic [1:0] nxt_corr;

	wire lock_ok = ~(cfg_ff.lock_reg_write_disable & wp_low);
	wire wr_lock_hit = wr_done & (addr_ff == ADR_LOCK);
	wire wr_lock = wr_lock_hit & lock_ok;
	wire wr_conf = wr_done & (addr_ff == ADR_CONF);
	wire wr_thr = wr_done & (addr_ff == ADR_THR);
	wire ecc_on = cfg_ff.ecc_enable;

	always_comb begin
		nxt_cfg = cfg_ff;
		if (cmd_done & is_wren)
			nxt_cfg.write_enable_latch = 1'b1;
		else if (cmd_done & is_wrdi)
			nxt_cfg.write_enable_latch = 1'b0;
		if (wr_lock) begin
			nxt_cfg.lock_reg_write_disable = rx_byte[LK_WD];
			nxt_cfg.lock_range = rx_byte[LK_RNG_HI:LK_RNG_LO];
		end
		if (wr_conf) begin
			nxt_cfg.protect_enable = rx_byte[CF_PROT];
			nxt_cfg.id_read_enable = rx_byte[CF_IDR];
			nxt_cfg.ecc_enable = rx_byte[CF_ECC];
			nxt_cfg.fast_read_enable = rx_byte[CF_FAST];
		end
		if (wr_thr)
			nxt_cfg.flip_threshold_field = rx_byte[TH_HI:TH_LO];
	end

	// Correction outcome of the last page read, graded against threshold
	always_comb begin
		nxt_corr = corr_ff;
		if (core.ecc_done & ecc_on) begin
			if (core.ecc_uncorr)
				nxt_corr = CS_UNCORR;
			else if (core.ecc_flips == 4'h0)
				nxt_corr = CS_NONE;
			else if (core.ecc_flips >= cfg_ff.flip_threshold_field)
				nxt_corr = CS_HIGH;
			else
				nxt_corr = CS_LOW;
		end
	end

	// Only power-on reset touches these; soft reset opcodes do not
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_ff <= '{lock_reg_write_disable: 1'b0, lock_range: DEF_RANGE,
				protect_enable: 1'b0, id_read_enable: 1'b0, ecc_enable: DEF_ECC,
				fast_read_enable: DEF_FAST, flip_threshold_field: DEF_THR,
				write_enable_latch: 1'b0};
			corr_ff <= CS_NONE;
		end else begin
			cfg_ff <= nxt_cfg;
			corr_ff <= nxt_corr;
		end
	end

	// ----------------------------------------
	// Read selection
	// ----------------------------------------
	wire [1:0] corr_view = ecc_on ? corr_ff : CS_NONE;
	wire [7:0] rd_lock = {cfg_ff.lock_reg_write_disable, 1'b0,
		cfg_ff.lock_range, 3'h0};
	wire [7:0] rd_conf = {cfg_ff.protect_enable, cfg_ff.id_read_enable, 1'b0,
		cfg_ff.ecc_enable, 1'b0, BBI_VAL, cfg_ff.fast_read_enable, 1'b0};
	wire [7:0] rd_stat = {2'h0, corr_view, core.program_fail_flag,
		core.erase_fail_flag, cfg_ff.write_enable_latch,
		core.op_in_progress};
	wire [7:0] rd_thr = {cfg_ff.flip_threshold_field, 4'h0};
	wire [7:0] rd_max = {core.max_flip_field, 1'b0, core.max_flip_sector};
	wire [31:0] rep = core.flip_report_field;
	wire [7:0] rd_addr = in_adr ? rx_byte : addr_ff;
	wire [7:0] rd_ecc =
		(rd_addr == ADR_SUM) ? core.flip_count_summary_field :
		(rd_addr == ADR_MAX) ? rd_max :
		(rd_addr == ADR_REP0) ? rep[7:0] :
		(rd_addr == ADR_REP1) ? rep[15:8] :
		(rd_addr == ADR_REP2) ? rep[23:16] :
		(rd_addr == ADR_REP3) ? rep[31:24] : 8'h00;
	wire [7:0] rd_mux =
		(rd_addr == ADR_LOCK) ? rd_lock :
		(rd_addr == ADR_CONF) ? rd_conf :
		(rd_addr == ADR_STAT) ? rd_stat :
		(rd_addr == ADR_THR) ? rd_thr :
		ecc_on ? rd_ecc : 8'h00;
	wire tx_load = byte_done & ((in_adr & is_get_ff) | in_rd);

	// ----------------------------------------
	// Output shifter
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_ff <= 8'h00;
			miso <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			if (tx_load) begin
				tx_ff <= rd_mux;
			end else if (sck_fall & in_rd) begin
				miso <= tx_ff[7];
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
			miso_oe <= cs_act & in_rd;
		end
	end

	// ----------------------------------------
	// Opcode side effects
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			soft_reset <= 1'b0;
			protect_go <= 1'b0;
		end else begin
			soft_reset <= cmd_done & is_rst;
			protect_go <= cmd_done & is_prot & cfg_ff.protect_enable;
		end
	end

	assign cfg = cfg_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_wel_set_on: assert property (cmd_done && is_wren |=> cfg_ff.write_enable_latch)
		else $error("write enable opcode did not set latch");
	a_wel_only_op: assert property (!(cmd_done && (is_wren || is_wrdi))
		|=> $stable(cfg_ff.write_enable_latch))
		else $error("latch moved without its opcodes");
	a_lock_guard: assert property (wr_lock_hit && cfg_ff.lock_reg_write_disable && wp_low
		|=> $stable(cfg_ff.lock_reg_write_disable) && $stable(cfg_ff.lock_range))
		else $error("guarded lock register was written");
	a_softrst_keeps: assert property (cmd_done && is_rst |=> $stable(cfg_ff))
		else $error("soft reset disturbed settings");
	a_rsvd_zero: assert property (((rd_lock & RSV_LOCK) == 8'h00)
		&& ((rd_conf & RSV_CONF) == 8'h00) && ((rd_stat & RSV_STAT) == 8'h00))
		else $error("reserved bit reads one");
	a_ecc_gated: assert property (!ecc_on |-> corr_view == CS_NONE
		&& (rd_addr == ADR_SUM ? rd_mux == 8'h00 : 1'b1))
		else $error("correction data visible with correction off");
	a_prot_gate: assert property (protect_go |-> $past(cfg_ff.protect_enable)
		&& $past(cmd_done))
		else $error("protect accepted while disabled");
	a_busy_live: assert property (tx_load && rd_addr == ADR_STAT
		|=> tx_ff[ST_OIP] == $past(core.op_in_progress))
		else $error("busy bit stale in status byte");
	a_ro_corr: assert property (!(core.ecc_done) |=> $stable(corr_ff))
		else $error("correction status moved without core result");
	a_thr_grade: assert property (core.ecc_done && ecc_on && !core.ecc_uncorr
		&& core.ecc_flips != 4'h0 && core.ecc_flips >= cfg_ff.flip_threshold_field
		|=> corr_ff == CS_HIGH)
		else $error("at-threshold grade wrong");

	// ----------------------------------------
	// Field write and opcode checks
	// ----------------------------------------
	a_wel_clr_on: assert property (cmd_done && is_wrdi
		|=> !cfg_ff.write_enable_latch)
		else $error("write disable opcode did not clear latch");
	a_lock_wd_write: assert property (wr_lock
		|=> cfg_ff.lock_reg_write_disable == $past(rx_byte[LK_WD]))
		else $error("lock write disable bit not written");
	a_range_write: assert property (wr_lock
		|=> cfg_ff.lock_range == $past(rx_byte[LK_RNG_HI:LK_RNG_LO]))
		else $error("lock range not written");
	a_prot_write: assert property (wr_conf
		|=> cfg_ff.protect_enable == $past(rx_byte[CF_PROT]))
		else $error("protect enable not written");
	a_prot_fire: assert property (cmd_done && is_prot && cfg_ff.protect_enable
		|=> protect_go)
		else $error("protect opcode not accepted while enabled");
	a_idr_write: assert property (wr_conf
		|=> cfg_ff.id_read_enable == $past(rx_byte[CF_IDR]))
		else $error("id read bit not written");
	a_ecc_write: assert property (wr_conf
		|=> cfg_ff.ecc_enable == $past(rx_byte[CF_ECC]))
		else $error("correction enable not written");
	a_fast_write: assert property (wr_conf
		|=> cfg_ff.fast_read_enable == $past(rx_byte[CF_FAST]))
		else $error("fast read enable not written");
	a_thr_write: assert property (wr_thr
		|=> cfg_ff.flip_threshold_field == $past(rx_byte[TH_HI:TH_LO]))
		else $error("threshold not written");
	a_ro_cfg: assert property (wr_done && addr_ff != ADR_LOCK
		&& addr_ff != ADR_CONF && addr_ff != ADR_THR |=> $stable(cfg_ff))
		else $error("read-only write changed settings");
	a_softrst_pulse: assert property (soft_reset
		|-> $past(cmd_done) && $past(is_rst))
		else $error("soft reset pulse without its opcode");

	// ----------------------------------------
	// Grading and read-out checks
	// ----------------------------------------
	a_grade_low: assert property (core.ecc_done && ecc_on && !core.ecc_uncorr
		&& core.ecc_flips != 4'h0 && core.ecc_flips < cfg_ff.flip_threshold_field
		|=> corr_ff == CS_LOW)
		else $error("below-threshold grade wrong");
	a_grade_uncorr: assert property (core.ecc_done && ecc_on && core.ecc_uncorr
		|=> corr_ff == CS_UNCORR)
		else $error("uncorrectable grade wrong");
	a_grade_none: assert property (core.ecc_done && ecc_on && !core.ecc_uncorr
		&& core.ecc_flips == 4'h0 |=> corr_ff == CS_NONE)
		else $error("clean grade wrong");
	a_ecc_hold: assert property (core.ecc_done && !ecc_on
		|=> $stable(corr_ff))
		else $error("grade moved with correction off");
	a_repeat_load: assert property (byte_done && in_rd
		|-> tx_load)
		else $error("read byte not reloaded");
	a_oe_read: assert property (miso_oe
		|-> $past(in_rd) && $past(cs_act))
		else $error("data out enabled outside read phase");
	a_stat_live: assert property (tx_load && rd_addr == ADR_STAT
		|=> tx_ff[3] == $past(core.program_fail_flag)
		&& tx_ff[2] == $past(core.erase_fail_flag))
		else $error("fail flags stale in status byte");
endmodule : sfr_top

// ===== tb/sfr_host.sv
// Host controller model for the feature register serial link, mode 0.
// Assumes the device shifts miso out after each sclk fall.
`timescale 1ns/1ns
module sfr_host (
	// Link pins
	output logic cs_b,
	output logic sclk,
	output logic mosi,
	input wire logic miso
);
	initial begin
		cs_b = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	// Idle data line keeps moving so no stale level is trusted
	always #80 if (cs_b) mosi = ~mosi;

	// ----------------------------------------
	// One byte, MSB first, sampled at sclk rise
	// ----------------------------------------
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			#16 mosi = tx[i];
			#80 sclk = 1'b1;
			rx[i] = miso;
			#64 sclk = 1'b0;
		end
	endtask : xbyte

	// Frame of nb bytes: opcode, address, then data in or out
	task automatic frame(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] dat,
		input int nb, output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] rx;
		#7 cs_b = 1'b0;
		xbyte(op, rx);
		if (nb > 1) xbyte(adr, rx);
		if (nb > 2) xbyte(dat, r0);
		if (nb > 3) xbyte(dat, r1);
		#40 cs_b = 1'b1;
		#200;
	endtask : frame
endmodule : sfr_host

// ===== tb/serial_nand_feature_registers_tb_top.sv
// Self-checking bench for the feature register bank.
// Assumes the host model in sfr_host drives the link pins.
`timescale 1ns/1ns
module serial_nand_feature_registers_tb_top import sfr_pkg::*;;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wp_b = 1'b1;
	sfr_core_s core = '0;
	logic cs_b, sclk, mosi, miso, miso_oe, soft_reset, protect_go;
	sfr_cfg_s cfg;
	int fail_count = 0;
	int samples_checked = 0;
	int n_rst = 0;
	int n_prot = 0;
	logic [7:0] r0, r1;
	logic [4:0] evs [4] = '{5'h02, 5'h03, 5'h11, 5'h00};
	logic [7:0] eexp [4] = '{8'h10, 8'h30, 8'h20, 8'h00};
	logic [7:0] roa [6] = '{ADR_SUM, ADR_MAX, ADR_REP0, ADR_REP1, ADR_REP2, ADR_REP3};
	logic [7:0] roe [6] = '{8'h5a, 8'ha5, 8'h21, 8'h43, 8'h65, 8'h87};

	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (soft_reset === 1'b1) n_rst++;
		if (protect_go === 1'b1) n_prot++;
	end

	sfr_top i_dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .wp_b(wp_b), .core(core), .cfg(cfg),
		.soft_reset(soft_reset), .protect_go(protect_go));
	sfr_host i_host (.cs_b(cs_b), .sclk(sclk), .mosi(mosi), .miso(miso));

	// ----------------------------------------
	// Checking and access tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up();
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_host.frame(CMD_GET, a, 8'h00, 3, r0, r1);
		chk($sformatf("reg_%h", a), exp, r0);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.frame(CMD_SET, a, d, 3, r0, r1);
	endtask : wr

	task automatic cmd(input logic [7:0] op);
		i_host.frame(op, 8'h00, 8'h00, 1, r0, r1);
	endtask : cmd

	task automatic ecc_ev(input logic [4:0] ev);
		@(posedge clk);
		core.ecc_done <= 1'b1;
		core.ecc_uncorr <= ev[4];
		core.ecc_flips <= ev[3:0];
		@(posedge clk);
		core.ecc_done <= 1'b0;
	endtask : ecc_ev

	initial begin
		#1000000;
		chk("run_time", 8'h00, 8'h01);
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		core.flip_count_summary_field <= 8'h5a;
		core.max_flip_field <= 4'ha;
		core.max_flip_sector <= 3'h5;
		core.flip_report_field <= 32'h87654321;
		repeat (4) @(posedge clk);
		rd(ADR_LOCK, 8'h38);
		rd(ADR_CONF, 8'h16);
		rd(ADR_STAT, 8'h00);
		rd(ADR_THR, 8'h00);
		wr(ADR_LOCK, 8'hff);
		rd(ADR_LOCK, 8'hb8);
		wr(ADR_CONF, 8'hff);
		rd(ADR_CONF, 8'hd6);
		chk("idr", 8'h01, {7'h0, cfg.id_read_enable});
		wr(ADR_STAT, 8'hff);
		rd(ADR_STAT, 8'h00);
		cmd(CMD_WREN);
		rd(ADR_STAT, 8'h02);
		wr(ADR_STAT, 8'h00);
		rd(ADR_STAT, 8'h02);
		cmd(CMD_WRDI);
		chk("wel", 8'h00, {7'h0, cfg.write_enable_latch});
		cmd(CMD_PROT);
		chk("prot_on", 8'h01, n_prot[7:0]);
		cmd(CMD_RST_A);
		cmd(CMD_RST_B);
		chk("soft_rst", 8'h02, n_rst[7:0]);
		rd(ADR_LOCK, 8'hb8);
		rd(ADR_CONF, 8'hd6);
		@(posedge clk) wp_b <= 1'b0;
		wr(ADR_LOCK, 8'h00);
		rd(ADR_LOCK, 8'hb8);
		@(posedge clk) wp_b <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			wr(ADR_LOCK, 8'(k << 3));
			rd(ADR_LOCK, 8'(k << 3));
			chk("range", 8'(k), {5'h0, cfg.lock_range});
		end
		wr(ADR_CONF, 8'h02);
		rd(ADR_CONF, 8'h06);
		chk("ecc_fast", 8'h01, {6'h0, cfg.ecc_enable, cfg.fast_read_enable});
		cmd(CMD_PROT);
		chk("prot_off", 8'h01, n_prot[7:0]);
		rd(ADR_SUM, 8'h00);
		ecc_ev(5'h03);
		rd(ADR_STAT, 8'h00);
		wr(ADR_CONF, 8'h10);
		wr(ADR_THR, 8'h3f);
		rd(ADR_THR, 8'h30);
		foreach (evs[k]) begin
			ecc_ev(evs[k]);
			rd(ADR_STAT, eexp[k]);
		end
		wr(ADR_REP0, 8'h00);
		foreach (roa[k]) rd(roa[k], roe[k]);
		i_host.frame(CMD_GET, ADR_CONF, 8'h00, 4, r0, r1);
		chk("repeat", 8'h14, r1);
		fork
			i_host.frame(CMD_GET, ADR_STAT, 8'h00, 4, r0, r1);
			begin
				for (int k = 0; k < 400 && miso_oe !== 1'b1; k++) @(posedge clk);
				if (miso_oe !== 1'b1) begin
					chk("oe_wait", 8'h01, 8'h00);
					wrap_up();
				end
				repeat (20) @(posedge clk);
				core.op_in_progress <= 1'b1;
				core.program_fail_flag <= 1'b1;
				core.erase_fail_flag <= 1'b1;
			end
		join
		chk("stat_b0", 8'h00, r0);
		chk("stat_b1", 8'h0d, r1);
		chk("oe_idle", 8'h00, {7'h0, miso_oe});
		wrap_up();
	end
endmodule : serial_nand_feature_registers_tb_top
